// [logic/tx_packet_pkg.sv]
/*
 * Shared constants and types of the transmit packet handler: register map,
 * field positions, reset values, status pin codes and the framer states.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package tx_packet_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_PKT_CTRL = 8'h00;
    localparam logic [7:0] OFS_PKT_LEN = 8'h04;
    localparam logic [7:0] OFS_MODEM_ONE = 8'h08;
    localparam logic [7:0] OFS_MODEM_TWO = 8'h0c;
    localparam logic [7:0] OFS_SYNC_HIGH = 8'h10;
    localparam logic [7:0] OFS_SYNC_LOW = 8'h14;
    localparam logic [7:0] OFS_PIN_CFG = 8'h18;
    localparam logic [7:0] OFS_COMMAND = 8'h1c;
    localparam logic [7:0] OFS_FIFO_DATA = 8'h20;
    localparam logic [7:0] OFS_QUEUE_LEVEL = 8'h24;
    localparam logic [7:0] OFS_PKT_STATUS = 8'h28;
    localparam logic [7:0] OFS_STATUS_BYTE = 8'h2c;
    localparam logic [7:0] OFS_PKT_CTRL_ALIAS = 8'h30;

    // packet_automation_control fields
    localparam int LEN_CFG_LSB = 0;
    localparam int CRC_EN_BIT = 2;
    localparam int LEGACY_BIT = 3;
    localparam int WHITEN_BIT = 6;
    // modem_config_one fields
    localparam int ERROR_CODING_ENABLE_BIT = 8;
    // command register bits
    localparam int CMD_TX_ON_BIT = 0;
    localparam int CMD_TX_OFF_BIT = 1;
    localparam int CMD_FLUSH_BIT = 2;

    // Length modes
    localparam logic [1:0] LEN_FIXED = 2'h0;
    localparam logic [1:0] LEN_VARIABLE = 2'h1;
    localparam logic [1:0] LEN_INFINITE = 2'h2;

    // Sync modes that double the sync word
    localparam logic [2:0] SYNC_DOUBLE_A = 3'h3;
    localparam logic [2:0] SYNC_DOUBLE_B = 3'h7;

    // Status pin selection codes
    localparam logic [5:0] PIN_QUEUE_ABOVE = 6'h02;
    localparam logic [5:0] PIN_QUEUE_FULL = 6'h03;
    localparam logic [5:0] PIN_SYNC_PACKET = 6'h06;

    // Reset values
    localparam logic [7:0] RST_PKT_CTRL = 8'h45;
    localparam logic [7:0] RST_PKT_LEN = 8'hff;
    localparam logic [7:0] RST_PREAMBLE = 8'h04;
    localparam logic [2:0] RST_SYNC_MODE = 3'h2;
    localparam logic [7:0] RST_SYNC_HIGH = 8'hd3;
    localparam logic [7:0] RST_SYNC_LOW = 8'h91;
    localparam logic [5:0] RST_PIN_CFG = 6'h06;

    // Stream constants
    localparam logic [7:0] PREAMBLE_BYTE = 8'haa;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [8:0] PN9_INIT = 9'h1ff;
    localparam logic [3:0] CONV_G0 = 4'hb;
    localparam logic [3:0] CONV_G1 = 4'hd;

    // Queue geometry
    localparam int QUEUE_DEPTH = 64;
    localparam int QUEUE_AW = 6;
    localparam logic [6:0] QUEUE_THRESHOLD = 7'h20;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PREAMBLE,
        ST_SYNC,
        ST_PAYLOAD,
        ST_CRC,
        ST_DONE,
        ST_UNDERRUN
    } framer_state_t;

    typedef struct packed {
        logic [1:0] length_config;
        logic crc_en;
        logic legacy_compat_enable;
        logic whitening_enable;
        logic error_coding_enable;
        logic [7:0] num_preamble;
        logic [2:0] sync_mode;
        logic [7:0] packet_length_value;
        logic [7:0] sync_high_byte;
        logic [7:0] sync_low_byte;
        logic [5:0] status_pin_config;
    } cfg_t;
endpackage
`default_nettype wire

// [logic/tx_packet_handler.sv]
/* Transmit packet handler: registers, transmit queue and serial framer.
   Assumes link_clk is asynchronous and much slower than core_clk. */
// Our own choices: register access over Avalon-MM and the register addresses.
// Notes on behaviour
// R1: Preamble of alternating bits, at least programmed count.
// R2: Extra preamble while queue empty, then sync.
// R3: Two-byte sync word follows preamble.
// R4: Sync modes 3 or 7 send sync twice.
// R5: Preamble and sync always inserted together.
// R6: Length mode 0: fixed length from register.
// R7: Length mode 1: first byte gives payload length.
// R8: Length mode 2: send until transmit switched off.
// R9: Fixed or variable packets hold 1 to 255 bytes.
// R10: Byte counter wraps; fixed end at length match.
// R11: Controller handles long packets by mode switching.
// R12: Optional CRC over queue bytes, two bytes appended.
// R13: Whitening XORs post-sync bits with PN9, all ones.
// R14: Whitening only while legacy compatibility is off.
// R15: Whitening precedes coding and interleaving.
// R16: Coding interleaves and encodes post-sync bits only.
// R17: Empty queue mid-packet: underrun until flush.
// R18: Controller writes length byte first in variable mode.
// R19: Controller changes configuration only while idle.
// R20: Controller avoids switching off mid first half-byte.
// R21: Status pin codes 6, 2 and 3.
// R22: Status byte reports queue count on writes.
// R23: Flush accepted only idle or underrun.
// R24: PN9 polynomial x9+x5+1, one step per bit.
// R25: CRC-16 0x8005, init all ones, high byte first.
`timescale 1ns/1ps
`default_nettype none
module tx_packet_handler
    import tx_packet_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset,
    // Avalon-MM register slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Modulator link and status pin
    input wire logic link_clk,
    output logic tx_data,
    output logic tx_active,
    output logic status_pin_zero
);
    // Whiten one byte MSB first, returning {next pn state, byte}
    function automatic logic [16:0] whiten_byte(input logic [7:0] din, input logic [8:0] pn);
        logic [8:0] s;
        logic [7:0] d;
        s = pn;
        d = din;
        for (int i = 7; i >= 0; i--) begin
            d[i] = din[i] ^ s[0];
            s = {s[0] ^ s[5], s[8:1]}; // R24
        end
        return {s, d};
    endfunction
    // Rate one half coder, then 4x4 interleave: rows written, columns read
    function automatic logic [18:0] code_byte(input logic [7:0] din, input logic [2:0] st);
        logic [3:0] win;
        logic [2:0] s;
        logic [15:0] c;
        logic [15:0] o;
        s = st;
        c = 16'h0000;
        for (int i = 7; i >= 0; i--) begin
            win = {din[i], s};
            c[2 * i + 1] = ^(win & CONV_G0);
            c[2 * i] = ^(win & CONV_G1);
            s = {din[i], s[2:1]};
        end
        for (int r = 0; r < 4; r++) begin
            for (int k = 0; k < 4; k++) begin
                o[15 - (k * 4 + r)] = c[15 - (r * 4 + k)];
            end
        end
        return {s, o};
    endfunction
    function automatic logic [15:0] crc_byte(input logic [15:0] crc, input logic [7:0] din);
        logic [15:0] c;
        c = crc;
        for (int i = 7; i >= 0; i--) begin
            c = (c[15] ^ din[i]) ? {c[14:0], 1'b0} ^ CRC_POLY : {c[14:0], 1'b0}; // R25
        end
        return c;
    endfunction
    cfg_t cfg;
    framer_state_t state, next_state;
    logic ack, bus_write, cmd_wr, tx_on_cmd, tx_off_cmd, flush_cmd;
    logic [7:0] queue_mem [QUEUE_DEPTH];
    logic [QUEUE_AW-1:0] wr_ptr, rd_ptr;
    logic [6:0] level;
    logic queue_empty, queue_full, push, pop, flush_ok;
    logic link_meta, link_sync, link_prev, bit_tick;
    logic [15:0] sreg, crc;
    logic [4:0] bits_left;
    logic [8:0] pn;
    logic [2:0] conv;
    logic [7:0] status_byte, pre_cnt, byte_cnt, len_reg, load_val, next_cnt;
    logic [1:0] sync_idx;
    logic len_seen, crc_idx, load_en, load_data, last_byte;
    logic [16:0] wh;
    logic [18:0] cd;
    logic whiten_on, double_sync, need;
    // One wait state; the request is taken while ack is high
    assign waitrequest = (read || write) && !ack;
    assign bus_write = write && ack;
    always_ff @(posedge core_clk) begin
        ack <= !reset && (read || write) && !ack;
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            readdata <= 32'h0000_0000;
        end else if (read && !ack) begin
            case (address)
                OFS_PKT_CTRL, OFS_PKT_CTRL_ALIAS: readdata <= {25'h0, cfg.whitening_enable, 2'h0,
                    cfg.legacy_compat_enable, cfg.crc_en, cfg.length_config};
                OFS_PKT_LEN: readdata <= {24'h0, cfg.packet_length_value};
                OFS_MODEM_ONE: readdata <= {23'h0, cfg.error_coding_enable, cfg.num_preamble};
                OFS_MODEM_TWO: readdata <= {29'h0, cfg.sync_mode};
                OFS_SYNC_HIGH: readdata <= {24'h0, cfg.sync_high_byte};
                OFS_SYNC_LOW: readdata <= {24'h0, cfg.sync_low_byte};
                OFS_PIN_CFG: readdata <= {26'h0, cfg.status_pin_config};
                OFS_QUEUE_LEVEL: readdata <= {24'h0, state == ST_UNDERRUN, level};
                OFS_PKT_STATUS: readdata <= {25'h0, state, 2'h0,
                    state == ST_UNDERRUN, status_pin_zero};
                OFS_STATUS_BYTE: readdata <= {24'h0, status_byte};
                default: readdata <= 32'h0000_0000;
            endcase
        end
    end
    // Configuration, meant to change only while idle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cfg.length_config <= RST_PKT_CTRL[1:0];
            cfg.crc_en <= RST_PKT_CTRL[CRC_EN_BIT];
            cfg.legacy_compat_enable <= RST_PKT_CTRL[LEGACY_BIT];
            cfg.whitening_enable <= RST_PKT_CTRL[WHITEN_BIT];
            cfg.error_coding_enable <= 1'b0;
            cfg.num_preamble <= RST_PREAMBLE;
            cfg.sync_mode <= RST_SYNC_MODE;
            cfg.packet_length_value <= RST_PKT_LEN;
            cfg.sync_high_byte <= RST_SYNC_HIGH;
            cfg.sync_low_byte <= RST_SYNC_LOW;
            cfg.status_pin_config <= RST_PIN_CFG;
        end else if (bus_write && byteenable[0]) begin
            case (address)
                OFS_PKT_CTRL, OFS_PKT_CTRL_ALIAS: begin
                    cfg.length_config <= writedata[LEN_CFG_LSB +: 2];
                    cfg.crc_en <= writedata[CRC_EN_BIT];
                    cfg.legacy_compat_enable <= writedata[LEGACY_BIT];
                    cfg.whitening_enable <= writedata[WHITEN_BIT];
                end
                OFS_PKT_LEN: cfg.packet_length_value <= writedata[7:0];
                OFS_MODEM_ONE: begin
                    cfg.num_preamble <= writedata[7:0];
                    if (byteenable[1]) begin
                        cfg.error_coding_enable <= writedata[ERROR_CODING_ENABLE_BIT];
                    end
                end
                OFS_MODEM_TWO: cfg.sync_mode <= writedata[2:0];
                OFS_SYNC_HIGH: cfg.sync_high_byte <= writedata[7:0];
                OFS_SYNC_LOW: cfg.sync_low_byte <= writedata[7:0];
                OFS_PIN_CFG: cfg.status_pin_config <= writedata[5:0];
                default: ;
            endcase
        end
    end
    assign cmd_wr = bus_write && byteenable[0] && address == OFS_COMMAND;
    always_ff @(posedge core_clk) begin
        tx_on_cmd <= !reset && cmd_wr && writedata[CMD_TX_ON_BIT];
        tx_off_cmd <= !reset && cmd_wr && writedata[CMD_TX_OFF_BIT];
        flush_cmd <= !reset && cmd_wr && writedata[CMD_FLUSH_BIT];
    end
    // Transmit queue; a write to a full queue is dropped
    assign queue_empty = level == 7'h00;
    assign queue_full = level == 7'(QUEUE_DEPTH);
    assign push = bus_write && byteenable[0] && address == OFS_FIFO_DATA && !queue_full;
    assign flush_ok = flush_cmd && (state == ST_IDLE || state == ST_UNDERRUN); // R23
    always_ff @(posedge core_clk) begin
        if (push) begin
            queue_mem[wr_ptr] <= writedata[7:0];
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset || flush_ok) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            level <= 7'h00;
        end else begin
            wr_ptr <= wr_ptr + QUEUE_AW'(push);
            rd_ptr <= rd_ptr + QUEUE_AW'(pop);
            level <= level + 7'(push) - 7'(pop);
        end
    end
    // Count before this write lands; only meaningful after writes
    always_ff @(posedge core_clk) begin
        if (reset) begin
            status_byte <= 8'h00;
        end else if (bus_write) begin
            status_byte <= {state == ST_UNDERRUN, level}; // R22
        end
    end
    // Two flops, then the edge detect compares the second with its delayed copy
    always_ff @(posedge core_clk) begin
        link_meta <= !reset && link_clk;
        link_sync <= !reset && link_meta;
        link_prev <= !reset && link_sync;
    end
    assign bit_tick = link_sync && !link_prev;
    assign need = bits_left == 5'd0;
    assign whiten_on = cfg.whitening_enable && !cfg.legacy_compat_enable; // R14
    assign double_sync = cfg.sync_mode == SYNC_DOUBLE_A || cfg.sync_mode == SYNC_DOUBLE_B; // R4
    always_comb begin
        next_state = state;
        load_en = 1'b0;
        load_data = 1'b0;
        load_val = PREAMBLE_BYTE;
        pop = 1'b0;
        next_cnt = byte_cnt + 8'h01;
        last_byte = 1'b0;
        case (state)
            ST_IDLE: begin
                if (tx_on_cmd) begin
                    next_state = ST_PREAMBLE;
                end
            end
            ST_PREAMBLE: begin
                if (need) begin
                    load_en = 1'b1; // R1
                    // Sync has no enable of its own: it always follows preamble
                    if (pre_cnt >= cfg.num_preamble && !queue_empty) begin // R2 R5
                        load_val = cfg.sync_high_byte; // R3
                        next_state = ST_SYNC;
                    end
                end
            end
            ST_SYNC: begin
                if (need) begin
                    load_en = 1'b1;
                    load_val = sync_idx[0] ? cfg.sync_low_byte : cfg.sync_high_byte; // R3 R4
                    if (sync_idx == 2'd3 || (sync_idx == 2'd1 && !double_sync)) begin
                        next_state = ST_PAYLOAD;
                    end
                end
            end
            ST_PAYLOAD: begin
                if (need) begin
                    if (queue_empty) begin
                        next_state = ST_UNDERRUN; // R17
                    end else begin
                        pop = 1'b1;
                        load_en = 1'b1;
                        load_data = 1'b1;
                        load_val = queue_mem[rd_ptr];
                        if (cfg.length_config == LEN_VARIABLE && !len_seen) begin
                            last_byte = queue_mem[rd_ptr] == 8'h00; // R7
                        end else if (cfg.length_config == LEN_VARIABLE) begin
                            last_byte = next_cnt == len_reg; // R7 R9
                        end else if (cfg.length_config == LEN_FIXED) begin
                            last_byte = next_cnt == cfg.packet_length_value; // R6 R10
                        end
                        if (last_byte) begin
                            next_state = cfg.crc_en ? ST_CRC : ST_DONE; // R12
                        end
                    end
                end
            end
            ST_CRC: begin
                if (need) begin
                    load_en = 1'b1;
                    load_data = 1'b1;
                    load_val = crc_idx ? crc[7:0] : crc[15:8]; // R25
                    if (crc_idx) begin
                        next_state = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                if (need) begin
                    next_state = ST_IDLE;
                end
            end
            ST_UNDERRUN: begin
                if (flush_ok) begin
                    next_state = ST_IDLE; // R17
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // Switching off ends any mode; mode 2 otherwise stops only at underrun on an empty queue
        if (tx_off_cmd && state != ST_IDLE && state != ST_UNDERRUN) begin
            next_state = ST_IDLE; // R8
            load_en = 1'b0;
            pop = 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= ST_IDLE;
            pre_cnt <= 8'h00;
            sync_idx <= 2'd0;
            byte_cnt <= 8'h00;
            len_reg <= 8'h00;
            len_seen <= 1'b0;
            crc_idx <= 1'b0;
        end else begin
            state <= next_state;
            if (state == ST_IDLE) begin
                pre_cnt <= 8'h00;
                sync_idx <= 2'd0;
                byte_cnt <= 8'h00;
                len_seen <= 1'b0;
                crc_idx <= 1'b0;
            end
            if (state == ST_PREAMBLE && load_en && pre_cnt != 8'hff) begin
                pre_cnt <= pre_cnt + 8'h01;
            end
            if ((state == ST_SYNC || next_state == ST_SYNC) && load_en) begin // R4
                sync_idx <= sync_idx + 2'd1;
            end
            if (pop) begin
                if (cfg.length_config == LEN_VARIABLE && !len_seen) begin
                    len_reg <= queue_mem[rd_ptr];
                    len_seen <= 1'b1;
                end else begin
                    byte_cnt <= next_cnt; // R10
                end
            end
            if (state == ST_CRC && load_en) begin
                crc_idx <= 1'b1;
            end
        end
    end
    // Data path: whitening feeds the coder, never the reverse
    always_comb begin
        wh = (load_data && whiten_on) ? whiten_byte(load_val, pn) : {pn, load_val};
        cd = code_byte(wh[7:0], conv); // R15
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            sreg <= 16'h0000;
            bits_left <= 5'd0;
            pn <= PN9_INIT;
            conv <= 3'h0;
            crc <= CRC_INIT;
        end else if (state == ST_IDLE || next_state == ST_IDLE) begin
            bits_left <= 5'd0;
            pn <= PN9_INIT; // R13
            conv <= 3'h0;
            crc <= CRC_INIT;
        end else if (load_en) begin
            pn <= wh[16:8]; // R13
            if (load_data && cfg.error_coding_enable) begin
                sreg <= cd[15:0]; // R16
                conv <= cd[18:16];
                bits_left <= 5'd16;
            end else begin
                sreg <= {wh[7:0], 8'h00};
                bits_left <= 5'd8;
            end
            if (pop) begin
                crc <= crc_byte(crc, load_val); // R12
            end
        end else if (bit_tick && !need) begin
            sreg <= {sreg[14:0], 1'b0};
            bits_left <= bits_left - 5'd1;
        end
    end
    assign tx_data = sreg[15];
    assign tx_active = state != ST_IDLE && state != ST_UNDERRUN;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            status_pin_zero <= 1'b0;
        end else begin
            case (cfg.status_pin_config)
                PIN_SYNC_PACKET: status_pin_zero <= state == ST_PAYLOAD || state == ST_CRC
                    || state == ST_DONE; // R21
                PIN_QUEUE_ABOVE: status_pin_zero <= level >= QUEUE_THRESHOLD; // R21
                PIN_QUEUE_FULL: status_pin_zero <= queue_full; // R21
                default: status_pin_zero <= 1'b0;
            endcase
        end
    end
endmodule // tx_packet_handler
`default_nettype wire

// [bench/tx_packet_chk.sv]
/* Port checker of the transmit packet handler: bus handshake and link pacing.
   Assumes it is bound to every handler instance and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module tx_packet_chk
    import tx_packet_pkg::*;
(
    // Clock, reset and register bus
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // Modulator link
    input wire logic link_clk,
    input wire logic tx_data,
    input wire logic tx_active
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    logic [3:0] since_edge;
    logic cmd;
    assign cmd = write && !waitrequest && address == OFS_COMMAND;
    // Bits may only move shortly after a sampled link edge
    always_ff @(posedge core_clk) begin
        if (reset || $rose(link_clk)) begin
            since_edge <= 4'h0;
        end else if (since_edge != 4'hf) begin
            since_edge <= since_edge + 4'h1;
        end
    end
    a_wait_first: assert property ($rose(read || write) |-> waitrequest)
        else $error("no wait state");
    a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("wait state too long");
    a_unmapped_zero: assert property (read && !waitrequest && address > 8'h33 |-> readdata == 0)
        else $error("unmapped read not zero");
    a_reset_clear: assert property (disable iff (1'b0) reset |=> !tx_active && !tx_data)
        else $error("link not quiet in reset");
    a_tx_start: assert property (cmd && writedata[0] && !tx_active |-> ##[1:3] tx_active)
        else $error("frame did not start");
    a_tx_stop: assert property (cmd && writedata[1] && tx_active |-> ##[1:3] !tx_active)
        else $error("frame did not stop");
    a_preamble_one: assert property ($rose(tx_active) |=> tx_data)
        else $error("preamble does not open with one");
    a_bit_hold: assert property (tx_active && $past(tx_active, 2) && since_edge > 4'h8
        |-> $stable(tx_data))
        else $error("bit moved without link edge");
endmodule // tx_packet_chk
bind tx_packet_handler tx_packet_chk chk (.core_clk(core_clk), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .link_clk(link_clk), .tx_data(tx_data), .tx_active(tx_active));
`default_nettype wire

// [bench/link_sink.sv]
/* Far end of the link: clocks bits only inside frames, gathers them MSB first.
   Assumes tx_data settles well before each rising link edge. */
`timescale 1ns/1ps
`default_nettype none
module link_sink (
    // Frame qualifier and link
    input wire logic run,
    input wire logic tx_data,
    output logic link_clk
);
    logic [7:0] shift;
    logic [7:0] q[$];
    int n;
    initial begin
        link_clk = 1'b0;
        n = 0;
        forever begin
            if (run === 1'b1) begin
                #40;
                link_clk = 1'b1;
                shift = {shift[6:0], tx_data};
                n++;
                if (n % 8 == 0) q.push_back(shift);
                #40;
                link_clk = 1'b0;
            end else begin
                // Clock stands still between frames
                n = 0;
                #7;
            end
        end
    end
endmodule // link_sink
`default_nettype wire

// [bench/tb.sv]
/* Bench of the transmit packet handler: Avalon tasks and packet expectations.
   Assumes the link sink clocks tx_data while tx_active is high. */
`timescale 1ns/1ps
`default_nettype none
module tb
    import tx_packet_pkg::*;
;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [7:0] address = 8'h00;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata, rd;
    logic waitrequest, tx_data, tx_active, status_pin_zero, link_clk;
    logic [7:0] exp_q[$];
    int errors = 0;
    int total_checks = 0;
    tx_packet_handler uut (.core_clk(core_clk), .reset(reset), .address(address), .read(read),
        .write(write), .byteenable(4'hf), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .link_clk(link_clk), .tx_data(tx_data),
        .tx_active(tx_active), .status_pin_zero(status_pin_zero));
    link_sink sink (.run(tx_active), .tx_data(tx_data), .link_clk(link_clk));
    initial begin
        forever #2.5 core_clk = ~core_clk;
    end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= d;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0);
        return c;
    endfunction
    function automatic logic [7:0] wh(inout logic [8:0] s, input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            b[i] = b[i] ^ s[0];
            s = {s[0] ^ s[5], s[8:1]};
        end
        return b;
    endfunction
    task automatic pkt(input logic [7:0] ctrl, input logic [2:0] sm, input logic [7:0] len,
        input logic [7:0] d[$]);
        logic [15:0] c;
        logic [8:0] s;
        int k;
        c = 16'hffff;
        s = 9'h1ff;
        exp_q = {8'haa, 8'haa, 8'h5a, 8'hc3};
        if (sm == 3'h3 || sm == 3'h7) exp_q = {exp_q, 8'h5a, 8'hc3};
        k = exp_q.size();
        foreach (d[i]) c = crc_upd(c, d[i]);
        exp_q = {exp_q, d};
        if (ctrl[2]) exp_q = {exp_q, c[15:8], c[7:0]};
        for (int i = k; i < exp_q.size(); i++) if (ctrl[6]) exp_q[i] = wh(s, exp_q[i]);
        bus(1'b1, OFS_PKT_CTRL, {24'h0, ctrl});
        bus(1'b1, OFS_MODEM_TWO, {29'h0, sm});
        bus(1'b1, OFS_PKT_LEN, {24'h0, len});
        foreach (d[i]) bus(1'b1, OFS_FIFO_DATA, {24'h0, d[i]});
        sink.q.delete();
        bus(1'b1, OFS_COMMAND, 32'h1);
        wait (tx_active === 1'b1);
        wait (tx_active === 1'b0);
        chk("byte count", exp_q.size(), sink.q.size());
        foreach (exp_q[i]) chk("stream byte", exp_q[i], sink.q[i]);
        bus(1'b0, OFS_PKT_STATUS, 32'h0);
        chk("end state", 32'h0, rd[6:4]);
    endtask
    initial begin
        logic [7:0] ra[9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h30, 8'h40};
        logic [7:0] rv[9] = '{8'h45, 8'hff, 8'h04, 8'h02, 8'hd3, 8'h91, 8'h06, 8'h45, 8'h00};
        repeat (10) @(posedge core_clk);
        reset <= 1'b0;
        foreach (ra[i]) begin
            bus(1'b0, ra[i], 32'h0);
            chk("reset value", rv[i], rd[7:0]);
        end
        bus(1'b1, OFS_MODEM_ONE, 32'h2);
        bus(1'b1, OFS_SYNC_HIGH, 32'h5a);
        bus(1'b1, OFS_SYNC_LOW, 32'hc3);
        pkt(8'h04, 3'h3, 8'h02, '{8'h11, 8'h22});
        pkt(8'h45, 3'h7, 8'h00, '{8'h02, 8'ha5, 8'h0f});
        pkt(8'h00, 3'h2, 8'h01, '{8'h3c});
        // Three bytes announced, one supplied
        bus(1'b1, OFS_PKT_LEN, 32'h3);
        bus(1'b1, OFS_FIFO_DATA, 32'h77);
        bus(1'b1, OFS_COMMAND, 32'h1);
        wait (tx_active === 1'b1);
        wait (tx_active === 1'b0);
        bus(1'b1, OFS_FIFO_DATA, 32'h78);
        bus(1'b0, OFS_STATUS_BYTE, 32'h0);
        chk("status byte", 32'h80, rd[7:0]);
        bus(1'b0, OFS_PKT_STATUS, 32'h0);
        chk("underrun state", 32'h62, rd[6:0] & 7'h72);
        bus(1'b1, OFS_COMMAND, 32'h4);
        bus(1'b0, OFS_QUEUE_LEVEL, 32'h0);
        chk("flushed level", 32'h0, rd[7:0]);
        bus(1'b1, OFS_PIN_CFG, 32'h3);
        repeat (65) bus(1'b1, OFS_FIFO_DATA, 32'h5);
        bus(1'b0, OFS_QUEUE_LEVEL, 32'h0);
        chk("full level", 32'h40, rd[7:0]);
        chk("full pin", 32'h1, status_pin_zero);
        bus(1'b1, OFS_PIN_CFG, 32'h2);
        bus(1'b1, OFS_COMMAND, 32'h4);
        bus(1'b0, OFS_QUEUE_LEVEL, 32'h0);
        chk("drained pin", 32'h0, status_pin_zero);
        bus(1'b1, OFS_PKT_CTRL, 32'h2);
        sink.q.delete();
        bus(1'b1, OFS_COMMAND, 32'h1);
        while (sink.q.size() < 4) @(posedge core_clk);
        chk("waiting preamble", 32'haa, sink.q[3]);
        repeat (4) @(posedge link_clk);
        bus(1'b1, OFS_COMMAND, 32'h2);
        bus(1'b0, OFS_PKT_STATUS, 32'h0);
        chk("stopped state", 32'h0, rd[6:4]);
        summarize();
    end
    initial begin
        #300000;
        errors++;
        summarize();
    end
endmodule // tb
`default_nettype wire
